/* File: hw/apc_control.sv */
// Converter primary control: AHB-Lite registers, sample/convert sequencing, DMA addressing
// Summary of operation
// - Control on bit runs the converter; clearing it switches it off.
// - With idle-stop set, operation halts while the device is idle.
// - Buffer mode one uses DMA destination; zero uses indirect addressing with buffer length.
// - Extended-buffer enable turns the DMA and buffer features on or off.
// - Buffer mode select only acts while extended-buffer enable is one.
// - Resolution bit picks 12-bit conversion when set, 10-bit when clear.
// - Format field: signed/unsigned fractional left-justified or integer right-justified.
// - Trigger code 0111 lets an internal counter end sampling and start conversion.
// - Codes 0101..0001 trigger from timer one, charge unit, timer five, three, int0.
// - Auto-sample restarts sampling right after conversion, setting the sample bit.
// - Hardware sets and clears sample and only sets done; software only clears done.
// - Control positions 14 and 3 always read zero.
// - One channel is wired internally to half the battery supply.
// - Indirect mode produces an 11-bit address ORed by the DMA controller.
`timescale 1ns/1ps
`default_nettype none
module apc_control (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic idle_mode,
	input wire logic timer_one_evt,
	input wire logic charge_time_evt,
	input wire logic timer_five_evt,
	input wire logic timer_three_evt,
	input wire logic ext_int_evt,
	input wire logic conv_done,
	input wire logic [11:0] conv_raw,
	output logic converter_enable,
	output logic sample_enable,
	output logic conv_start,
	output logic resolution_12,
	output logic [4:0] channel_select,
	output logic battery_monitor_connect,
	output logic dma_req,
	output logic [15:0] dma_data,
	output logic [10:0] dma_ia,
	output logic dma_extended_mode,
	output logic irq
);
	apc_pkg::apc_regs_t s_reg;
	apc_pkg::apc_regs_t s_next;
	logic run;
	logic addr_ok;
	logic trig_hit;
	logic pia_mode;

	// Idle stop freezes the sequencer rather than resetting it, so a conversion resumes
	assign run = s_reg.on && !(s_reg.idle_stop && idle_mode);
	assign addr_ok = hsel && hready && htrans[1];
	assign pia_mode = s_reg.ext_en && !s_reg.buf_mode;

	always_comb begin
		logic [15:0] ctrl_img;
		logic [15:0] fmt_val;
		logic [11:0] chan_base;
		logic [6:0] len_mask;
		logic [31:0] wd;
		ctrl_img = 16'h0000;
		fmt_val = 16'h0000;
		chan_base = 12'h000;
		len_mask = 7'h00;
		wd = hwdata;
		s_next = s_reg;
		s_next.conv_start = 1'b0;
		s_next.dma_req = 1'b0;
		s_next.rdata = 32'h0000_0000;

		// Unimplemented positions never stored and never driven on read
		ctrl_img[apc_pkg::BIT_ON] = s_reg.on;
		ctrl_img[apc_pkg::BIT_IDLE_STOP] = s_reg.idle_stop;
		ctrl_img[apc_pkg::BIT_BUF_MODE] = s_reg.buf_mode;
		ctrl_img[apc_pkg::BIT_EXT_EN] = s_reg.ext_en;
		ctrl_img[apc_pkg::BIT_RES12] = s_reg.res12;
		ctrl_img[apc_pkg::BIT_FMT_LO +: 2] = s_reg.fmt;
		ctrl_img[apc_pkg::BIT_TRIG_LO +: 4] = s_reg.trig;
		ctrl_img[apc_pkg::BIT_AUTO_SAMPLE] = s_reg.auto_sample;
		ctrl_img[apc_pkg::BIT_SAMPLE] = (s_reg.phase == apc_pkg::ST_SAMPLE);
		ctrl_img[apc_pkg::BIT_DONE] = s_reg.done;

		// Address phase: reads answer from a flop in the data phase
		s_next.wr_pend = addr_ok && hwrite;
		s_next.wr_addr = haddr[7:0];
		if (addr_ok && !hwrite) begin
			unique case (haddr[7:0])
				apc_pkg::OFS_CTRL_ONE: s_next.rdata = {16'h0000, ctrl_img};
				apc_pkg::OFS_CTRL_FOUR: begin
					s_next.rdata[apc_pkg::BIT_BUF_LEN_LO +: 3] = s_reg.buf_len;
					s_next.rdata[apc_pkg::BIT_CHAN_LO +: 5] = s_reg.chan;
				end
				apc_pkg::OFS_RESULT: s_next.rdata = {16'h0000, s_reg.result};
				apc_pkg::OFS_IADDR: s_next.rdata = {21'h000000, s_reg.ia};
				apc_pkg::OFS_STATUS: begin
					s_next.rdata = {30'h00000000, s_reg.stat};
					s_next.stat = 2'h0;
				end
				apc_pkg::OFS_MASK: s_next.rdata = {30'h00000000, s_reg.mask};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end

		// Data phase write
		if (s_reg.wr_pend) begin
			unique case (s_reg.wr_addr)
				apc_pkg::OFS_CTRL_ONE: begin
					s_next.on = wd[apc_pkg::BIT_ON];
					s_next.idle_stop = wd[apc_pkg::BIT_IDLE_STOP];
					s_next.buf_mode = wd[apc_pkg::BIT_BUF_MODE];
					s_next.ext_en = wd[apc_pkg::BIT_EXT_EN];
					s_next.res12 = wd[apc_pkg::BIT_RES12];
					s_next.fmt = wd[apc_pkg::BIT_FMT_LO +: 2];
					s_next.trig = wd[apc_pkg::BIT_TRIG_LO +: 4];
					s_next.auto_sample = wd[apc_pkg::BIT_AUTO_SAMPLE];
					// Done is clear-only from software
					if (!wd[apc_pkg::BIT_DONE]) begin
						s_next.done = 1'b0;
					end
					// Reserved trigger codes are flagged and never fire
					if (wd[apc_pkg::BIT_TRIG_LO + 3] ||
						wd[apc_pkg::BIT_TRIG_LO +: 4] == apc_pkg::TRIG_RESERVED6) begin
						s_next.stat[apc_pkg::BIT_IRQ_BAD_TRIG] = 1'b1;
					end
					// Software sets the sample bit only from READY and clears it only from SAMPLE
					if (s_reg.phase == apc_pkg::ST_READY && wd[apc_pkg::BIT_SAMPLE]) begin
						s_next.phase = apc_pkg::ST_SAMPLE;
						s_next.cnt = apc_pkg::AUTO_SAMPLE_LOAD;
					end
					if (s_reg.phase == apc_pkg::ST_SAMPLE && !wd[apc_pkg::BIT_SAMPLE]) begin
						if (s_reg.trig == apc_pkg::TRIG_SOFTWARE) begin
							s_next.phase = apc_pkg::ST_CONVERT;
							s_next.conv_start = 1'b1;
						end else begin
							s_next.phase = apc_pkg::ST_READY;
						end
					end
				end
				apc_pkg::OFS_CTRL_FOUR: begin
					s_next.buf_len = wd[apc_pkg::BIT_BUF_LEN_LO +: 3];
					s_next.chan = wd[apc_pkg::BIT_CHAN_LO +: 5];
				end
				apc_pkg::OFS_MASK: s_next.mask = wd[1:0];
				default: s_next.mask = s_next.mask;
			endcase
		end

		// Trigger selection while sampling
		unique case (s_reg.trig)
			apc_pkg::TRIG_AUTO: trig_hit = (s_reg.cnt == 8'h00);
			apc_pkg::TRIG_TIMER_ONE: trig_hit = timer_one_evt;
			apc_pkg::TRIG_CHARGE_TIME: trig_hit = charge_time_evt;
			apc_pkg::TRIG_TIMER_FIVE: trig_hit = timer_five_evt;
			apc_pkg::TRIG_TIMER_THREE: trig_hit = timer_three_evt;
			apc_pkg::TRIG_EXT_INT0: trig_hit = ext_int_evt;
			default: trig_hit = 1'b0;
		endcase

		// Result formatting
		unique case (s_reg.fmt)
			apc_pkg::FMT_UINT: fmt_val = s_reg.res12 ? {4'h0, conv_raw} :
				{6'h00, conv_raw[9:0]};
			apc_pkg::FMT_SINT: fmt_val = s_reg.res12 ?
				{{5{~conv_raw[11]}}, conv_raw[10:0]} :
				{{7{~conv_raw[9]}}, conv_raw[8:0]};
			apc_pkg::FMT_UFRAC: fmt_val = s_reg.res12 ? {conv_raw, 4'h0} :
				{conv_raw[9:0], 6'h00};
			apc_pkg::FMT_SFRAC: fmt_val = s_reg.res12 ? {~conv_raw[11], conv_raw[10:0], 4'h0} :
				{~conv_raw[9], conv_raw[8:0], 6'h00};
		endcase

		// Indirect address: channel above a 2^len-word slot, word aligned
		chan_base = 12'({s_reg.chan, 7'h00} >> (3'h7 - s_reg.buf_len));
		len_mask = 7'((8'h01 << s_reg.buf_len) - 8'h01);

		// Sequencer; a register write above takes priority in its cycle
		// A write moves CONVERT only by clearing the on bit; otherwise that phase steps anyway and no done pulse is lost
		if (!s_next.on) begin
			s_next.phase = apc_pkg::ST_OFF;
			s_next.conv_start = 1'b0;
		end else if (run && (!s_reg.wr_pend || s_reg.phase == apc_pkg::ST_CONVERT)) begin
			unique case (s_reg.phase)
				apc_pkg::ST_OFF: s_next.phase = apc_pkg::ST_READY;
				apc_pkg::ST_READY: begin
					if (s_reg.auto_sample) begin
						s_next.phase = apc_pkg::ST_SAMPLE;
						s_next.cnt = apc_pkg::AUTO_SAMPLE_LOAD;
					end
				end
				apc_pkg::ST_SAMPLE: begin
					if (s_reg.cnt != 8'h00) begin
						s_next.cnt = s_reg.cnt - 8'h01;
					end
					if (trig_hit) begin
						s_next.phase = apc_pkg::ST_CONVERT;
						s_next.conv_start = 1'b1;
					end
				end
				apc_pkg::ST_CONVERT: begin
					if (conv_done) begin
						s_next.result = fmt_val;
						s_next.done = 1'b1;
						s_next.stat[apc_pkg::BIT_IRQ_DONE] = 1'b1;
						s_next.dma_req = s_reg.ext_en;
						if (pia_mode) begin
							s_next.ia = {chan_base[9:0] | {3'h0, s_reg.offs}, 1'b0};
							s_next.offs = (s_reg.offs + 7'h01) & len_mask;
						end else begin
							s_next.ia = 11'h000;
						end
						if (s_reg.auto_sample) begin
							s_next.phase = apc_pkg::ST_SAMPLE;
							s_next.cnt = apc_pkg::AUTO_SAMPLE_LOAD;
						end else begin
							s_next.phase = apc_pkg::ST_READY;
						end
					end
				end
			endcase
		end
		if (s_next.phase == apc_pkg::ST_OFF) begin
			s_next.offs = 7'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			s_reg.buf_len <= apc_pkg::RST_BUF_LEN;
			s_reg.chan <= apc_pkg::RST_CHAN;
			s_reg.mask <= apc_pkg::RST_MASK;
			s_reg.phase <= apc_pkg::ST_OFF;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_reg.rdata;
	assign converter_enable = s_reg.on;
	assign sample_enable = (s_reg.phase == apc_pkg::ST_SAMPLE);
	assign conv_start = s_reg.conv_start;
	assign resolution_12 = s_reg.res12;
	assign channel_select = s_reg.chan;
	// Divider switch closes only while sampling, limiting battery drain
	assign battery_monitor_connect = sample_enable &&
		(s_reg.chan == apc_pkg::VBAT_CHANNEL);
	assign dma_req = s_reg.dma_req;
	assign dma_data = s_reg.result;
	assign dma_ia = s_reg.ia;
	assign dma_extended_mode = s_reg.ext_en && s_reg.buf_mode;
	assign irq = |(s_reg.stat & s_reg.mask);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Antecedents skip data-phase cycles where a write may redirect the sequencer, except in res12_a and sint10_a
	off_quiet_a: assert property (!converter_enable |-> !sample_enable && !conv_start)
		else $error("converter active while switched off");
	idle_hold_a: assert property (
		s_reg.on && s_reg.idle_stop && idle_mode && !s_reg.wr_pend |=> $stable(s_reg.phase))
		else $error("sequencer moved during idle stop");
	ext_mode_a: assert property (dma_req && dma_extended_mode |-> dma_ia == 11'h000)
		else $error("indirect address used in extended buffer mode");
	dma_gate_a: assert property (dma_req |-> $past(s_reg.ext_en))
		else $error("transfer request with extended buffer disabled");
	dma_on_a: assert property (dma_req |-> converter_enable)
		else $error("transfer request while switched off");
	res10_a: assert property (
		s_reg.phase == apc_pkg::ST_CONVERT && conv_done && run && !s_reg.wr_pend &&
		s_reg.fmt == apc_pkg::FMT_UINT && !s_reg.res12
		|=> dma_data[15:10] == 6'h00 && dma_data[9:0] == $past(conv_raw[9:0]))
		else $error("10-bit right-justified result wrong");
	res12_a: assert property (
		s_reg.phase == apc_pkg::ST_CONVERT && conv_done && run &&
		s_reg.fmt == apc_pkg::FMT_UINT && s_reg.res12
		|=> dma_data == {4'h0, $past(conv_raw)})
		else $error("12-bit right-justified result wrong");
	sint10_a: assert property (
		s_reg.phase == apc_pkg::ST_CONVERT && conv_done && run &&
		s_reg.fmt == apc_pkg::FMT_SINT && !s_reg.res12
		|=> dma_data == {{7{~$past(conv_raw[9])}}, $past(conv_raw[8:0])})
		else $error("signed integer result wrong");
	frac_a: assert property (
		s_reg.phase == apc_pkg::ST_CONVERT && conv_done && run && !s_reg.wr_pend &&
		s_reg.fmt == apc_pkg::FMT_SFRAC && s_reg.res12
		|=> dma_data == {~$past(conv_raw[11]), $past(conv_raw[10:0]), 4'h0})
		else $error("signed fractional result wrong");
	auto_conv_a: assert property (
		s_reg.phase == apc_pkg::ST_SAMPLE && s_reg.on &&
		!idle_mode && !s_reg.wr_pend && s_reg.trig == apc_pkg::TRIG_AUTO &&
		s_reg.cnt == 8'h01 ##1 !s_reg.wr_pend && !idle_mode
		|=> conv_start && s_reg.phase == apc_pkg::ST_CONVERT)
		else $error("auto-convert did not start on count end");
	timer_trig_a: assert property (
		s_reg.phase == apc_pkg::ST_SAMPLE && run && !s_reg.wr_pend &&
		s_reg.trig == apc_pkg::TRIG_TIMER_ONE && timer_one_evt |=> conv_start)
		else $error("timer one trigger missed");
	bad_trig_a: assert property (
		s_reg.phase == apc_pkg::ST_SAMPLE &&
		(s_reg.trig[3] || s_reg.trig == apc_pkg::TRIG_RESERVED6)
		|=> !conv_start)
		else $error("reserved trigger code started a conversion");
	sw_conv_a: assert property (
		s_reg.wr_pend && s_reg.wr_addr == apc_pkg::OFS_CTRL_ONE &&
		s_reg.phase == apc_pkg::ST_SAMPLE && s_reg.trig == apc_pkg::TRIG_SOFTWARE &&
		hwdata[apc_pkg::BIT_ON] && !hwdata[apc_pkg::BIT_SAMPLE]
		|=> conv_start && s_reg.phase == apc_pkg::ST_CONVERT)
		else $error("software sample clear did not start conversion");
	start_pulse_a: assert property (conv_start |=> !conv_start)
		else $error("conversion start longer than one cycle");
	auto_restart_a: assert property (
		s_reg.phase == apc_pkg::ST_CONVERT && conv_done && run &&
		!s_reg.wr_pend && s_reg.auto_sample |=> sample_enable && s_reg.done)
		else $error("sampling not restarted after conversion");
	// Set wins over a same-cycle software clear or status read
	done_set_a: assert property (
		s_reg.phase == apc_pkg::ST_CONVERT && conv_done && run &&
		(!s_reg.wr_pend || s_reg.wr_addr != apc_pkg::OFS_CTRL_ONE || hwdata[apc_pkg::BIT_ON])
		|=> s_reg.done && s_reg.stat[apc_pkg::BIT_IRQ_DONE])
		else $error("conversion end did not set done");
	unimpl_a: assert property (
		addr_ok && !hwrite && haddr[7:0] == apc_pkg::OFS_CTRL_ONE
		|=> hrdata[14] == 1'b0 && hrdata[3] == 1'b0)
		else $error("unimplemented control bit read as one");
	vbat_a: assert property (battery_monitor_connect |->
		converter_enable && channel_select == apc_pkg::VBAT_CHANNEL)
		else $error("battery divider connected while off or on another channel");
	ia_align_a: assert property (dma_req && !dma_extended_mode |-> dma_ia[0] == 1'b0)
		else $error("indirect address not word aligned");
	offs_off_a: assert property (s_reg.phase == apc_pkg::ST_OFF |-> s_reg.offs == 7'h00)
		else $error("indirect offset kept while off");

	// Main scenarios
	cover_auto_c: cover property (s_reg.auto_sample && conv_done ##1 sample_enable);
	cover_pia_c: cover property (dma_req && !dma_extended_mode && dma_ia != 11'h000);
	cover_irq_c: cover property (!irq ##1 irq);
	cover_idle_c: cover property (s_reg.idle_stop && idle_mode && sample_enable);
	cover_ext_c: cover property (dma_req && dma_extended_mode);
endmodule
`default_nettype wire

/* File: hw/apc_pkg.sv */
// Package for the converter primary control block: offsets, fields, states, timing
package apc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFS_CTRL_FOUR = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam logic [7:0] OFS_IADDR = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	// Control register one field positions
	localparam int BIT_ON = 15;
	localparam int BIT_IDLE_STOP = 13;
	localparam int BIT_BUF_MODE = 12;
	localparam int BIT_EXT_EN = 11;
	localparam int BIT_RES12 = 10;
	localparam int BIT_FMT_LO = 8;
	localparam int BIT_TRIG_LO = 4;
	localparam int BIT_AUTO_SAMPLE = 2;
	localparam int BIT_SAMPLE = 1;
	localparam int BIT_DONE = 0;
	// Control register four field positions
	localparam int BIT_BUF_LEN_LO = 0;
	localparam int BIT_CHAN_LO = 8;
	// Status and mask layout
	localparam int BIT_IRQ_DONE = 0;
	localparam int BIT_IRQ_BAD_TRIG = 1;
	// Reset values
	localparam logic [15:0] RST_CTRL_ONE = 16'h0000;
	localparam logic [2:0] RST_BUF_LEN = 3'h0;
	localparam logic [4:0] RST_CHAN = 5'h00;
	localparam logic [1:0] RST_MASK = 2'h0;
	// Channel internally wired to half the battery supply; index is arbitrary
	localparam logic [4:0] VBAT_CHANNEL = 5'h1a;
	// Trigger source codes
	localparam logic [3:0] TRIG_SOFTWARE = 4'h0;
	localparam logic [3:0] TRIG_EXT_INT0 = 4'h1;
	localparam logic [3:0] TRIG_TIMER_THREE = 4'h2;
	localparam logic [3:0] TRIG_TIMER_FIVE = 4'h3;
	localparam logic [3:0] TRIG_CHARGE_TIME = 4'h4;
	localparam logic [3:0] TRIG_TIMER_ONE = 4'h5;
	localparam logic [3:0] TRIG_RESERVED6 = 4'h6;
	localparam logic [3:0] TRIG_AUTO = 4'h7;
	// Output formats
	localparam logic [1:0] FMT_UINT = 2'h0;
	localparam logic [1:0] FMT_SINT = 2'h1;
	localparam logic [1:0] FMT_UFRAC = 2'h2;
	localparam logic [1:0] FMT_SFRAC = 2'h3;
	// Auto-convert sampling time
	localparam int CLK_PERIOD_NS = 50;
	localparam int AUTO_SAMPLE_NS = 1000;
	localparam int AUTO_SAMPLE_CYC = (AUTO_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] AUTO_SAMPLE_LOAD = 8'(AUTO_SAMPLE_CYC - 1);

	typedef enum logic [1:0] {ST_OFF, ST_READY, ST_SAMPLE, ST_CONVERT} apc_phase_t;

	typedef struct packed {
		logic on;
		logic idle_stop;
		logic buf_mode;
		logic ext_en;
		logic res12;
		logic [1:0] fmt;
		logic [3:0] trig;
		logic auto_sample;
		logic done;
		apc_phase_t phase;
		logic [7:0] cnt;
		logic [2:0] buf_len;
		logic [4:0] chan;
		logic [15:0] result;
		logic [10:0] ia;
		logic [6:0] offs;
		logic [1:0] stat;
		logic [1:0] mask;
		logic conv_start;
		logic dma_req;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} apc_regs_t;
endpackage

/* File: verification/apc_core_model.sv */
// Converter core model: answers each conversion start after a short or a long delay
`timescale 1ns/1ps
`default_nettype none
module apc_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic conv_start,
	input wire logic slow,
	input wire logic [11:0] next_raw,
	output logic conv_done,
	output logic [11:0] conv_raw
);
	int cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 0;
			conv_done <= 1'b0;
			conv_raw <= 12'h5a5;
		end else begin
			conv_done <= 1'b0;
			// Code toggles outside the done pulse, so stale data never looks valid
			conv_raw <= ~conv_raw;
			if (conv_start) cnt <= slow ? 14 : 2;
			else if (cnt != 0) cnt <= cnt - 1;
			if (!conv_start && cnt == 1) begin
				conv_done <= 1'b1;
				conv_raw <= next_raw;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/adc_primary_control_test.sv */
// Testbench for the converter primary control block
`timescale 1ns/1ps
`default_nettype none
module adc_primary_control_test;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, idle_mode, slow;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, lfsr, q;
	logic [5:1] evt;
	logic conv_done, conv_on, sample_control, conv_start, res12, bat, dma_req, dma_ext, irq;
	logic [11:0] conv_raw, next_raw;
	logic [4:0] chan;
	logic [15:0] dma_data, cfg;
	logic [10:0] dma_ia;
	logic [26:0] exp_q[$];
	logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
	int fail_count = 0, n_compared = 0, n_start = 0, cyc = 0, off = 0, n;
	assign hready = hreadyout;

	apc_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle_mode(idle_mode),
		.timer_one_evt(evt[5]), .charge_time_evt(evt[4]), .timer_five_evt(evt[3]),
		.timer_three_evt(evt[2]), .ext_int_evt(evt[1]), .conv_done(conv_done),
		.conv_raw(conv_raw), .converter_enable(conv_on), .sample_enable(sample_control),
		.conv_start(conv_start), .resolution_12(res12), .channel_select(chan),
		.battery_monitor_connect(bat), .dma_req(dma_req), .dma_data(dma_data),
		.dma_ia(dma_ia), .dma_extended_mode(dma_ext), .irq(irq));
	apc_core_model core (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
		.slow(slow), .next_raw(next_raw), .conv_done(conv_done), .conv_raw(conv_raw));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic end_of_test();
		if (fail_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Signed forms are the offset code with its top bit flipped
	function automatic logic [15:0] fmt_exp(input logic [11:0] raw, input logic r,
		input logic [1:0] f);
		logic [11:0] v;
		v = r ? raw : {2'h0, raw[9:0]};
		case (f)
			2'h0: return {4'h0, v};
			2'h1: return r ? {{5{~v[11]}}, v[10:0]} : {{7{~v[9]}}, v[8:0]};
			2'h2: return r ? {v, 4'h0} : {v[9:0], 6'h0};
			default: return r ? {~v[11], v[10:0], 4'h0} : {~v[9], v[8:0], 6'h0};
		endcase
	endfunction

	// Results are matched in arrival order as the converter hands them to DMA
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
		if (conv_start === 1'b1) n_start++;
		if (dma_req === 1'b1) begin
			if (exp_q.size() == 0) chk("dma_req", 1, 0);
			else begin
				chk("dma_data", dma_data, exp_q[0][15:0]);
				chk("dma_ia", dma_ia, exp_q[0][26:16]);
				void'(exp_q.pop_front());
			end
		end
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	// Lets the write's effects land before anything is sampled
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		@(posedge hclk);
	endtask

	task automatic expect_result(input logic [15:0] c);
		logic [10:0] ia;
		lfsr = lfsr_next(lfsr);
		next_raw <= lfsr[11:0];
		ia = c[12] ? 11'h0 : {3'h0, 5'h1a, 2'(off), 1'b0};
		exp_q.push_back({ia, fmt_exp(lfsr[11:0], c[10], c[9:8])});
		if (!c[12]) off = (off + 1) % 4;
	endtask

	task automatic convert(input logic [15:0] c);
		wr(apc_pkg::OFS_CTRL_ONE, {16'h0, c | 16'h0002});
		chk("sample_enable", sample_control, 1);
		chk("battery", bat, 1);
		expect_result(c);
		wr(apc_pkg::OFS_CTRL_ONE, {16'h0, c});
		chk("conv_start", conv_start, 1);
		while (exp_q.size() != 0) @(posedge hclk);
	endtask

	initial begin
		hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
		idle_mode = 0; evt = 0; slow = 0; next_raw = 0; lfsr = 32'h6d72; hresetn = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 0);
			chk("reset read", q, 0);
		end
		chk("hresp", hresp, 0);
		wr(8'h20, 32'hffffffff);
		bus(1'b0, 8'h20, 0);
		chk("unmapped", q, 0);
		wr(apc_pkg::OFS_CTRL_ONE, 32'hffffffff);
		bus(1'b0, apc_pkg::OFS_CTRL_ONE, 0);
		chk("ctrl one", q, 32'h0000bff6);
		bus(1'b0, apc_pkg::OFS_STATUS, 0);
		chk("status reserved", q, 32'h2);
		wr(apc_pkg::OFS_CTRL_ONE, 32'h0060);
		bus(1'b0, apc_pkg::OFS_STATUS, 0);
		chk("status code six", q, 32'h2);
		wr(apc_pkg::OFS_CTRL_FOUR, 32'hffffffff);
		bus(1'b0, apc_pkg::OFS_CTRL_FOUR, 0);
		chk("ctrl four", q, 32'h1f07);
		wr(apc_pkg::OFS_CTRL_FOUR, 32'h1a02);
		chk("channel", chan, 32'h1a);
		wr(apc_pkg::OFS_CTRL_ONE, 32'h1000);
		chk("ext mode off", dma_ext, 0);
		chk("conv off", conv_on, 0);
		wr(apc_pkg::OFS_CTRL_ONE, 32'h1800);
		chk("ext mode on", dma_ext, 1);
		for (int i = 0; i < 8; i++) begin
			cfg = {5'h11, i[2], i[1:0], 8'h00};
			wr(apc_pkg::OFS_CTRL_ONE, {16'h0, cfg});
			chk("res12", res12, i[2]);
			chk("conv on", conv_on, 1);
			slow <= i[0];
			convert(cfg);
		end
		chk("irq masked", irq, 0);
		wr(apc_pkg::OFS_MASK, 32'h1);
		chk("irq", irq, 1);
		bus(1'b0, apc_pkg::OFS_STATUS, 0);
		chk("status", q, 32'h1);
		chk("irq cleared", irq, 0);
		bus(1'b0, apc_pkg::OFS_CTRL_ONE, 0);
		chk("done set", q, {16'h0, cfg | 16'h0001});
		wr(apc_pkg::OFS_CTRL_ONE, {16'h0, cfg});
		bus(1'b0, apc_pkg::OFS_CTRL_ONE, 0);
		chk("done cleared", q, {16'h0, cfg});
		convert(16'h9800);
		for (int c = 1; c <= 5; c++) begin
			cfg = {8'h88, 4'(c), 4'h0};
			wr(apc_pkg::OFS_CTRL_ONE, {16'h0, cfg});
			wr(apc_pkg::OFS_CTRL_ONE, {16'h0, cfg | 16'h0002});
			n = n_start;
			evt <= 5'(1 << (c % 5));
			@(posedge hclk);
			evt <= 5'h0;
			repeat (3) @(posedge hclk);
			chk("wrong trigger", n_start, n);
			expect_result(cfg);
			evt <= 5'(1 << (c - 1));
			@(posedge hclk);
			evt <= 5'h0;
			@(posedge hclk);
			chk("trigger start", conv_start, 1);
			while (exp_q.size() != 0) @(posedge hclk);
		end
		wr(apc_pkg::OFS_CTRL_ONE, 32'ha874);
		idle_mode <= 1'b1;
		n = n_start;
		wr(apc_pkg::OFS_CTRL_ONE, 32'ha876);
		repeat (40) @(posedge hclk);
		chk("idle frozen", n_start, n);
		expect_result(16'ha874);
		idle_mode <= 1'b0;
		n = 0;
		while (conv_start !== 1'b1) begin
			@(posedge hclk);
			n++;
		end
		chk("auto convert", n >= 18 && n <= 22, 1);
		while (exp_q.size() != 0) @(posedge hclk);
		@(posedge hclk);
		chk("auto sample", sample_control, 1);
		wr(apc_pkg::OFS_CTRL_ONE, 32'h0);
		chk("off", conv_on | sample_control | bat, 0);
		end_of_test();
	end
endmodule
`default_nettype wire
